// ### verilog/rti_pkg.sv
// Overview of operation
// R1: Count register at port F2 loads timer.
// R2: Mode register at port F3 sets counting.
// R3: Reset gives 1 ms tick without programming.
// R4: Tick feeds local interrupt controller request.
// R5: Local controller merges requests into level seven.
// R6: Controllers latch requests during foreign bus ownership.
// R7: Variant gates which resources foreign masters reach.
// R8: Polling host keeps level seven masked.
// R9: Periodic mode reloads count, pulses tick.
package rti_pkg;

    localparam logic [7:0]  RTI_PORT_COUNT   = 8'hF2;
    localparam logic [7:0]  RTI_PORT_MODE    = 8'hF3;
    localparam logic [7:0]  RTI_PORT_LIC_REQ = 8'hF4;
    localparam logic [7:0]  RTI_PORT_LIC_MSK = 8'hF5;

    localparam int          RTI_CLK_HZ       = 50000000;
    localparam int          RTI_TIMER_HZ     = 1000000;
    localparam int          RTI_PRESCALE     = RTI_CLK_HZ / RTI_TIMER_HZ;
    localparam int          RTI_PERIOD_US    = 1000;

    localparam logic [7:0]  RTI_RST_COUNT    = 8'hFA;
    localparam logic [7:0]  RTI_RST_EXTRA    = 8'h04;
    localparam logic [5:0]  RTI_PRE_LAST     = 6'(RTI_PRESCALE - 1);
    localparam logic [15:0] RTI_RST_RELOAD   = 16'(RTI_PERIOD_US);

    localparam logic [7:0]  RTI_RST_MODE     = 8'h34;
    localparam int          RTI_MODE_LSB     = 1;
    localparam logic [2:0]  RTI_MODE_ONESHOT = 3'h0;
    localparam logic [2:0]  RTI_MODE_RATE    = 3'h2;
    localparam logic [2:0]  RTI_MODE_SQUARE  = 3'h3;

    localparam int          RTI_NREQ         = 8;
    localparam int          RTI_REQ_TICK     = 0;
    localparam int          RTI_REQ_IOC      = 1;
    localparam int          RTI_REQ_PIO      = 2;
    localparam logic [7:0]  RTI_RST_MASK     = 8'hFF;

    typedef enum logic [1:0] {
        RTI_ST_IDLE = 2'b00,
        RTI_ST_RUN  = 2'b01,
        RTI_ST_DONE = 2'b10
    } rti_state_t;

    function automatic logic rti_periodic(input logic [7:0] mode);
        logic [2:0] m;
        m = mode[RTI_MODE_LSB +: 3];
        return (m[1:0] == RTI_MODE_RATE[1:0]);
    endfunction : rti_periodic

endpackage : rti_pkg

// ### verilog/rti_tick_if.sv
`timescale 1ns/1ps
interface rti_tick_if;
    logic        load;
    logic [15:0] reload;
    logic [7:0]  mode;
    logic        tick;
    modport ctl (output load, output reload, output mode, input tick);
    modport tmr (input load, input reload, input mode, output tick);
endinterface : rti_tick_if

// ### verilog/rti_counter.sv
`timescale 1ns/1ps
module rti_counter
    import rti_pkg::*;
(
    input wire logic   sys_clk,
    input wire logic   reset_n,
    rti_tick_if.tmr    bus
);

    // ***************************************************************
    // Prescaler and down counter.
    // ***************************************************************
    logic [5:0]  pre_q,   pre_d;
    logic [15:0] cnt_q,   cnt_d;
    logic        tick_q,  tick_d;
    rti_state_t  state_q, state_d;

    always_comb begin
        pre_d   = pre_q;
        cnt_d   = cnt_q;
        tick_d  = 1'b0;
        state_d = state_q;
        if (bus.load) begin
            pre_d   = '0;
            cnt_d   = bus.reload;
            state_d = RTI_ST_RUN;
        end else if (state_q == RTI_ST_RUN) begin
            pre_d = (pre_q == RTI_PRE_LAST) ? 6'h00 : pre_q + 6'h01;
            if (pre_q == RTI_PRE_LAST) begin
                if (cnt_q <= 16'h0001) begin
                    tick_d = 1'b1;
                    if (rti_periodic(bus.mode)) begin
                        cnt_d = bus.reload; // [R9]
                    end else begin
                        state_d = RTI_ST_DONE;
                    end
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_q   <= '0;
            cnt_q   <= RTI_RST_RELOAD; // [R3]
            tick_q  <= 1'b0;
            state_q <= RTI_ST_RUN;
        end else begin
            pre_q   <= pre_d;
            cnt_q   <= cnt_d;
            tick_q  <= tick_d;
            state_q <= state_d;
        end
    end

    assign bus.tick = tick_q;

endmodule : rti_counter

// ### verilog/rti_timer.sv
`timescale 1ns/1ps
module rti_timer
    import rti_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic       newer_processor_card,
    input  wire logic       local_owner,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] io_addr,
    input  wire logic [7:0] io_wdata,
    input  wire logic       io_controller_subsystem_req,
    input  wire logic       parallel_io_subsystem_req,
    input  wire logic [4:0] onboard_req,
    output logic      [7:0] io_rdata,
    output logic            io_ack,
    output logic            rtc_tick,
    output logic            level7_int
);

    // ***************************************************************
    // Port decoding.
    // ***************************************************************
    typedef enum logic [2:0] {
        RTI_SEL_NONE  = 3'b000,
        RTI_SEL_COUNT = 3'b001,
        RTI_SEL_MODE  = 3'b010,
        RTI_SEL_REQ   = 3'b011,
        RTI_SEL_MASK  = 3'b100
    } rti_sel_t;

    function automatic rti_sel_t rti_decode(input logic [7:0] addr);
        rti_sel_t sel_v;
        unique case (addr)
            RTI_PORT_COUNT:   sel_v = RTI_SEL_COUNT;
            RTI_PORT_MODE:    sel_v = RTI_SEL_MODE;
            RTI_PORT_LIC_REQ: sel_v = RTI_SEL_REQ;
            RTI_PORT_LIC_MSK: sel_v = RTI_SEL_MASK;
            default:          sel_v = RTI_SEL_NONE;
        endcase
        return sel_v;
    endfunction : rti_decode

    // True for the ports of the local interrupt controller.
    function automatic logic rti_ctl_port(input rti_sel_t s);
        return (s == RTI_SEL_REQ) || (s == RTI_SEL_MASK);
    endfunction : rti_ctl_port

    // ***************************************************************
    // Access gate for the host and foreign masters.
    // ***************************************************************
    logic        ok;
    logic        wr_ok;
    logic        rd_ok;
    rti_sel_t    sel;

    assign ok    = local_owner | newer_processor_card; // [R7]
    assign wr_ok = io_wr & ok;
    assign rd_ok = io_rd & ok;
    assign sel   = rti_decode(io_addr);

    // ***************************************************************
    // Interval counter.
    // ***************************************************************
    rti_tick_if tif ();

    rti_counter u_counter (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .bus     (tif.tmr)
    );

    // ***************************************************************
    // Count and mode registers.
    // ***************************************************************
    logic [7:0]  count_q, count_d;
    logic [7:0]  mode_q,  mode_d;
    logic        load_q,  load_d;

    always_comb begin
        count_d = count_q;
        mode_d  = mode_q;
        load_d  = 1'b0;
        if (wr_ok) begin
            unique case (sel)
                RTI_SEL_COUNT: begin
                    count_d = io_wdata; // [R1]
                    load_d  = 1'b1;
                end
                RTI_SEL_MODE: begin
                    mode_d = io_wdata; // [R2]
                end
                default: begin
                    load_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= RTI_RST_COUNT; // [R3]
            mode_q  <= RTI_RST_MODE;
            load_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            mode_q  <= mode_d;
            load_q  <= load_d;
        end
    end

    assign tif.load   = load_q;
    assign tif.reload = (count_q == RTI_RST_COUNT)
                        ? RTI_RST_RELOAD : {8'h00, count_q}; // [R3]
    assign tif.mode   = mode_q;

    // ***************************************************************
    // Local interrupt controller: request latch and mask.
    // ***************************************************************
    logic [7:0]  src;
    logic        clr_req;
    logic [7:0]  clr_mask;
    logic [7:0]  req_q,   req_d;
    logic [7:0]  msk_q,   msk_d;

    // Sources: tick, both io subsystems, on-board lines.
    assign src = {onboard_req, parallel_io_subsystem_req,
                  io_controller_subsystem_req, tif.tick}; // [R4] [R5]
    assign clr_req  = wr_ok && (sel == RTI_SEL_REQ);
    assign clr_mask = {RTI_NREQ{clr_req}} & io_wdata;

    // A new request wins over a clear in the same cycle.
    genvar gi;
    generate
        for (gi = 0; gi < RTI_NREQ; gi = gi + 1) begin : g_req
            assign req_d[gi] = src[gi] | (req_q[gi] & ~clr_mask[gi]); // [R6]
        end
    endgenerate

    always_comb begin
        msk_d = msk_q;
        if (wr_ok && (sel == RTI_SEL_MASK)) begin
            msk_d = io_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            req_q <= '0;
            msk_q <= RTI_RST_MASK;
        end else begin
            req_q <= req_d;
            msk_q <= msk_d;
        end
    end

    // ***************************************************************
    // Host answer: acknowledge and read data.
    // ***************************************************************
    logic [7:0]  rd_q,    rd_d;
    logic        ack_q,   ack_d;

    always_comb begin
        ack_d = 1'b0;
        rd_d  = rd_q;
        if (wr_ok) begin
            unique case (sel)
                RTI_SEL_COUNT: ack_d = 1'b1;
                RTI_SEL_MODE:  ack_d = 1'b1;
                default:       ack_d = rti_ctl_port(sel) & local_owner; // [R7]
            endcase
        end
        if (rd_ok) begin
            unique case (sel)
                RTI_SEL_COUNT: rd_d = count_q;
                RTI_SEL_REQ:   rd_d = req_q;
                default:       rd_d = 8'h00;
            endcase
            ack_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_q  <= '0;
            ack_q <= 1'b0;
        end else begin
            rd_q  <= rd_d;
            ack_q <= ack_d;
        end
    end

    // ***************************************************************
    // Level seven interrupt.
    // ***************************************************************
    logic        irq_q,   irq_d;

    always_comb begin
        irq_d = |(req_q & ~msk_q); // [R5]
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // ***************************************************************
    // Tick output.
    // ***************************************************************
    logic        tick_q,  tick_d;

    always_comb begin
        tick_d = tif.tick; // [R4]
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= tick_d;
        end
    end

    assign io_rdata   = rd_q;
    assign io_ack     = ack_q;
    assign rtc_tick   = tick_q;
    assign level7_int = irq_q;

endmodule : rti_timer

// ### verification/rti_timer_sva.sv
`timescale 1ns/1ps
module rti_timer_sva (
    input logic       sys_clk,
    input logic       reset_n,
    input logic       newer_processor_card,
    input logic       local_owner,
    input logic       io_wr,
    input logic       io_rd,
    input logic [7:0] io_addr,
    input logic       io_ack,
    input logic       rtc_tick,
    input logic       level7_int
);
    wire fgn = !(local_owner || newer_processor_card);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    property p_src; io_ack |-> $past(io_wr || io_rd); endproperty
    a_src: assert property (p_src) else $error("stray ack");
    property p_old; (io_wr || io_rd) && fgn |=> !io_ack; endproperty
    a_old: assert property (p_old) else $error("foreign ack");
    property p_rd; io_rd && local_owner |=> io_ack; endproperty
    a_rd: assert property (p_rd) else $error("no read ack");
    property p_cnt; io_wr && local_owner && io_addr == 8'hF2 |=> io_ack;
    endproperty
    a_cnt: assert property (p_cnt) else $error("no count ack");
    property p_mod; io_wr && local_owner && io_addr == 8'hF3 |=> io_ack;
    endproperty
    a_mod: assert property (p_mod) else $error("no mode ack");
    property p_new; io_rd && newer_processor_card && io_addr == 8'hF2
        |=> io_ack; endproperty
    a_new: assert property (p_new) else $error("no shared ack");
    property p_tck; rtc_tick |=> !rtc_tick [*8]; endproperty
    a_tck: assert property (p_tck) else $error("long tick");
    property p_l7; $fell(level7_int) |-> $past(io_wr) || $past(io_wr, 2);
    endproperty
    a_l7: assert property (p_l7) else $error("level 7 lost");
    c_tck: cover property (rtc_tick);
    c_l7r: cover property ($rose(level7_int));
    c_l7f: cover property ($fell(level7_int));
    c_fgn: cover property (fgn && io_rd);
endmodule : rti_timer_sva

// ### verification/rti_host_model.sv
`timescale 1ns/1ps
module rti_host_model (
    input  logic       sys_clk,
    output logic       io_wr,
    output logic       io_rd,
    output logic [7:0] io_addr,
    output logic [7:0] io_wdata,
    input  logic       io_ack,
    input  logic [7:0] io_rdata
);
    initial {io_wr, io_rd, io_addr, io_wdata} = 18'h00000;
    // Polling uses reads and writes; level seven stays masked until port F5 is written.
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [7:0] d, output logic k, output logic [7:0] q);
        @(negedge sys_clk);
        {io_wr, io_rd, io_addr, io_wdata} = {w, !w, a, d};
        @(negedge sys_clk);
        k = io_ack;
        q = io_rdata;
        {io_wr, io_rd, io_addr, io_wdata} = {2'h0, ~a, ~d};
    endtask : xfer
endmodule : rti_host_model

// ### verification/tb_rtc_timer_interrupt_source.sv
`timescale 1ns/1ps
module tb_rtc_timer_interrupt_source;
    logic sys_clk = 1'b0, reset_n = 1'b0;
    logic newer_processor_card = 1'b0, local_owner = 1'b1;
    logic io_controller_subsystem_req, parallel_io_subsystem_req;
    logic [4:0] onboard_req;
    logic [6:0] rq = 7'h00;
    logic io_wr, io_rd, io_ack, rtc_tick, level7_int, k;
    logic [7:0] io_addr, io_wdata, io_rdata, q;
    int err_total = 0, n_compared = 0, n, lic = 0, seed = 32'h3460834e;
    time t_q[$];
    assign {onboard_req, parallel_io_subsystem_req,
        io_controller_subsystem_req} = rq;
    rti_timer i_dut (
        .sys_clk                     (sys_clk),
        .reset_n                     (reset_n),
        .newer_processor_card        (newer_processor_card),
        .local_owner                 (local_owner),
        .io_wr                       (io_wr),
        .io_rd                       (io_rd),
        .io_addr                     (io_addr),
        .io_wdata                    (io_wdata),
        .io_controller_subsystem_req (io_controller_subsystem_req),
        .parallel_io_subsystem_req   (parallel_io_subsystem_req),
        .onboard_req                 (onboard_req),
        .io_rdata                    (io_rdata),
        .io_ack                      (io_ack),
        .rtc_tick                    (rtc_tick),
        .level7_int                  (level7_int)
    );
    rti_host_model i_host (
        .sys_clk  (sys_clk),
        .io_wr    (io_wr),
        .io_rd    (io_rd),
        .io_addr  (io_addr),
        .io_wdata (io_wdata),
        .io_ack   (io_ack),
        .io_rdata (io_rdata)
    );
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (rtc_tick === 1'b1) t_q.push_back($time);
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic final_report;
        if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    task automatic io(input logic w, input logic [7:0] a, input logic [7:0] d);
        i_host.xfer(w, a, d, k, q);
    endtask : io
    task automatic tk(input int m);
        t_q.delete();
        for (int i = 0; i < 60000 && t_q.size() < m; i++) @(negedge sys_clk);
    endtask : tk
    initial begin
        #3000000;
        err_total++;
        final_report();
    end
    initial begin
        repeat (10) @(negedge sys_clk);
        reset_n = 1'b1;
        tk(1);
        chk(16'(t_q[0] inside {[999000:1002000]}), 16'h1);
        io(1, 8'hF3, 8'h34);
        chk(k, 16'h1);
        n = 2 + $unsigned($random(seed)) % 60;
        io(1, 8'hF2, 8'(n));
        chk(k, 16'h1);
        tk(2);
        chk(16'(t_q[1] - t_q[0]), 16'(n * 1000));
        io(1, 8'hF4, 8'hFF);
        for (int b = 0; b < 8; b++) begin
            io(1, 8'hF5, ~8'(1 << b));
            if (b == 0) tk(1);
            local_owner = 1'b0;
            rq = 7'(1 << b >> 1);
            @(negedge sys_clk);
            rq = 7'h00;
            local_owner = 1'b1;
            repeat (2) @(negedge sys_clk);
            chk(level7_int, 16'h1);
            lic = lic | ((1 << b) & 8'hFE);
            io(0, 8'hF4, 8'h00);
            chk(16'(q & 8'hFE), 16'(lic));
            io(1, 8'hF4, 8'(1 << b));
            lic = lic & ~(1 << b);
            repeat (2) @(negedge sys_clk);
            chk(level7_int, 16'h0);
        end
        local_owner = 1'b0;
        io(0, 8'hF2, 8'h00);
        chk(k, 16'h0);
        newer_processor_card = 1'b1;
        io(0, 8'hF2, 8'h00);
        chk(k, 16'h1);
        chk(16'(q), 16'(8'(n)));
        newer_processor_card = 1'b0;
        local_owner = 1'b1;
        io(1, 8'hF3, 8'h30);
        chk(k, 16'h1);
        io(1, 8'hF2, 8'h03);
        repeat (4) @(negedge sys_clk);
        t_q.delete();
        repeat (600) @(negedge sys_clk);
        chk(16'(t_q.size()), 16'h1);
        io(1, 8'hF3, 8'h34);
        io(1, 8'hF2, 8'h03);
        reset_n = 1'b0;
        repeat (3) @(negedge sys_clk);
        reset_n = 1'b1;
        chk(16'(level7_int), 16'h0);
        io(0, 8'hF2, 8'h00);
        chk(16'(q), 16'(rti_pkg::RTI_RST_COUNT));
        t_q.delete();
        repeat (600) @(negedge sys_clk);
        chk(16'(t_q.size()), 16'h0);
        final_report();
    end
endmodule : tb_rtc_timer_interrupt_source
bind rti_timer rti_timer_sva i_sva (
    .sys_clk              (sys_clk),
    .reset_n              (reset_n),
    .newer_processor_card (newer_processor_card),
    .local_owner          (local_owner),
    .io_wr                (io_wr),
    .io_rd                (io_rd),
    .io_addr              (io_addr),
    .io_ack               (io_ack),
    .rtc_tick             (rtc_tick),
    .level7_int           (level7_int)
);
